// file: verilog/rsf_reset_source_flags.sv
//----------------------------------------------------------------
// Reset source flags with oscillator trim, AHB-Lite slave
//----------------------------------------------------------------
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
module rsf_reset_source_flags
    import rsf_pkg::*;
#(
    parameter logic [7:0] TRIM_HIGH_RESET = RSF_TRIM_HIGH_RST
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic powerOnReset,
    input wire logic watchdogResetCause,
    input wire logic undervoltageResetCause,
    input wire logic lowVoltageDetectorEnable,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    output logic [9:0] oscTrimWord
);

    //------------------------------------------------------------
    // Declarations
    //------------------------------------------------------------
    rsf_bus_state_t busState;            // Read path state
    rsf_bus_state_t next_busState;       // Read path next state
    logic [7:0] busOff;                  // Offset of the open transfer
    logic wrPending;                     // Write data phase this cycle
    logic addrPhase;                     // Address phase accepted now
    logic [1:0] trimLow;                 // Trim low bits
    logic [7:0] trimHigh;                // Trim high bits
    logic [7:0] intStatus;               // Sticky event bits
    logic [7:0] intMask;                 // Interrupt enables
    logic [7:0] eventVec;                // Events in this cycle
    logic [7:0] readValue;               // Register selected for read
    logic readStrobe;                    // Read fetch cycle
    logic watchdogResetFlag;             // Watchdog caused last reset
    logic undervoltageResetFlag;         // Undervoltage caused a reset
    logic watchdogFlagClear;             // Software zero on bit 4
    logic undervoltageFlagClear;         // Read of flags register
    logic [3:0] busSel;                  // Decoded register select

    //------------------------------------------------------------
    // Offset decode
    //------------------------------------------------------------
    // Returns one-hot select: flags, trim high, status, mask.
    // Upper address bits are not decoded, so the map aliases.
    function automatic logic [3:0] regSelect(input logic [7:0] off);
        logic [3:0] sel;
        sel = 4'h0;
        unique case (off)
            RSF_FLAGS_OFF: sel = 4'h1;
            RSF_TRIMHI_OFF: sel = 4'h2;
            RSF_STAT_OFF: sel = 4'h4;
            RSF_MASK_OFF: sel = 4'h8;
            default: sel = 4'h0;   // Unmapped
        endcase
        return sel;
    endfunction

    // Decoded select of the open transfer, shared by every user but the read mux
    assign busSel = regSelect(busOff);

    //------------------------------------------------------------
    // Address phase capture
    //------------------------------------------------------------
    // Only NONSEQ or SEQ with the bus ready opens a transfer
    assign addrPhase = hsel && htrans[1] && hready;

    // Offset held for the data phase that follows
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busOff <= 8'h00;
        end
        else if (addrPhase)
        begin
            busOff <= haddr[7:0];
        end
    end

    // Write data arrives one cycle after its address phase
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wrPending <= 1'b0;
        end
        else
        begin
            wrPending <= addrPhase && hwrite;
        end
    end

    //------------------------------------------------------------
    // Read path state machine
    //------------------------------------------------------------
    // A read takes one wait state so that read data and the read
    // side effects come from flip-flops
    always_comb
    begin
        next_busState = busState;
        unique case (busState)
            RSF_BUS_IDLE:
            begin
                if (addrPhase && !hwrite)
                begin
                    next_busState = RSF_BUS_RDWAIT;
                end
            end
            RSF_BUS_RDWAIT:
            begin
                next_busState = RSF_BUS_RDDONE;
            end
            RSF_BUS_RDDONE:
            begin
                // Back to back read opens straight into a new wait
                if (addrPhase && !hwrite)
                begin
                    next_busState = RSF_BUS_RDWAIT;
                end
                else
                begin
                    next_busState = RSF_BUS_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            busState <= RSF_BUS_IDLE;
        end
        else
        begin
            busState <= next_busState;
        end
    end

    // Wait only while the read value is being fetched
    assign hreadyout = (busState != RSF_BUS_RDWAIT);

    // Every answer is OKAY, unmapped offsets included
    assign hresp = 1'b0;

    // Fetch cycle of a read
    assign readStrobe = (busState == RSF_BUS_RDWAIT);

    //------------------------------------------------------------
    // Read data
    //------------------------------------------------------------
    // Flags register: reserved bits read zero, the two flags give
    // the reset source to software
    always_comb
    begin
        readValue = 8'h00;
        unique case (regSelect(busOff))
            4'h1: readValue = {1'b0, trimLow, watchdogResetFlag, 1'b0,
                undervoltageResetFlag, 2'h0};
            4'h2: readValue = trimHigh;
            4'h4: readValue = intStatus;
            4'h8: readValue = intMask;
            default: readValue = 8'h00;   // Unmapped reads zero
        endcase
    end

    // Read data held until the next read is fetched
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            hrdata <= 32'h0;
        end
        else if (readStrobe)
        begin
            hrdata <= {24'h0, readValue};
        end
    end

    //------------------------------------------------------------
    // Flag clear strobes
    //------------------------------------------------------------
    // A one written to bit 4 does nothing
    assign watchdogFlagClear = wrPending && busSel[0]
        && !hwdata[RSF_WDG_BIT];

    // Reading the flags register clears the undervoltage flag
    assign undervoltageFlagClear = readStrobe
        && busSel[0];

    //------------------------------------------------------------
    // Reset source flags
    //------------------------------------------------------------
    rsf_flag_keeper u_flag_keeper (
        .core_clk(core_clk),
        .powerOnReset(powerOnReset),
        .watchdogResetCause(watchdogResetCause),
        .undervoltageResetCause(undervoltageResetCause),
        .lowVoltageDetectorEnable(lowVoltageDetectorEnable),
        .watchdogFlagClear(watchdogFlagClear),
        .undervoltageFlagClear(undervoltageFlagClear),
        .watchdogResetFlag(watchdogResetFlag),
        .undervoltageResetFlag(undervoltageResetFlag)
    );

    //------------------------------------------------------------
    // Oscillator trim
    //------------------------------------------------------------
    // Trim low bits reset high; reserved write bits are dropped
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trimLow <= RSF_TRIM_LOW_RST;
        end
        else if (wrPending && busSel[0])
        begin
            trimLow <= hwdata[RSF_TRIM_MSB:RSF_TRIM_LSB];
        end
    end

    // Companion trim high register
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            trimHigh <= TRIM_HIGH_RESET;
        end
        else if (wrPending && busSel[1])
        begin
            trimHigh <= hwdata[7:0];
        end
    end

    // Full trim word to the oscillator
    assign oscTrimWord = {trimHigh, trimLow};

    //------------------------------------------------------------
    // Interrupt status and mask
    //------------------------------------------------------------
    // Events share the bit positions of the flags register
    always_comb
    begin
        eventVec = 8'h00;
        eventVec[RSF_WDG_BIT] = watchdogResetCause;
        eventVec[RSF_UV_BIT] = undervoltageResetCause
            && lowVoltageDetectorEnable;
    end

    // Sticky status; a cause comes with reset, so reset keeps it,
    // and a set beats the read clear of the same cycle
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            intStatus <= eventVec;
        end
        else if (readStrobe && busSel[2])
        begin
            intStatus <= eventVec;
        end
        else
        begin
            intStatus <= intStatus | eventVec;
        end
    end

    // Mask, only the two event bits are writable
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            intMask <= RSF_MASK_RST;
        end
        else if (wrPending && busSel[3])
        begin
            intMask <= hwdata[7:0] & RSF_EVENT_BITS;
        end
    end

    // Level interrupt while any unmasked status bit is set
    assign irq = |(intStatus & intMask);

    //------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------
    a_wdg_flag_set: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        (watchdogResetCause && !undervoltageResetCause)
        |=> watchdogResetFlag)
        else $error("watchdog flag not set by watchdog reset");

    a_wdg_flag_clear: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        (watchdogFlagClear && !watchdogResetCause
        && !undervoltageResetCause) |=> !watchdogResetFlag)
        else $error("watchdog flag not cleared by zero write");

    a_uv_clears_wdg: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        undervoltageResetCause |=> !watchdogResetFlag)
        else $error("watchdog flag survived undervoltage reset");

    a_uv_flag_set: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        (undervoltageResetCause && lowVoltageDetectorEnable)
        |=> undervoltageResetFlag)
        else $error("undervoltage flag not set");

    a_uv_read_clear: assert property (
        @(posedge core_clk) disable iff (powerOnReset || reset)
        (hsel && htrans[1] && hready && !hwrite
        && haddr[7:0] == RSF_FLAGS_OFF && !undervoltageResetCause)
        ##1 !undervoltageResetCause |=> !undervoltageResetFlag)
        else $error("undervoltage flag not cleared by read");

    a_uv_flag_hold: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        (undervoltageResetFlag && !undervoltageFlagClear)
        |=> undervoltageResetFlag)
        else $error("undervoltage flag lost without a read");

    a_wdg_one_write: assert property (
        @(posedge core_clk) disable iff (powerOnReset)
        (wrPending && busSel[0] && hwdata[RSF_WDG_BIT]
        && !watchdogResetCause && !undervoltageResetCause)
        |=> $stable(watchdogResetFlag))
        else $error("writing one changed watchdog flag");

    a_trim_reset: assert property (
        @(posedge core_clk)
        reset |=> oscTrimWord[1:0] == RSF_TRIM_LOW_RST)
        else $error("trim low bits not high after reset");

    a_flags_layout: assert property (
        @(posedge core_clk) disable iff (reset)
        (busState == RSF_BUS_RDDONE && busOff == RSF_FLAGS_OFF)
        |-> (hrdata[7] == 1'b0 && hrdata[3] == 1'b0
        && hrdata[1:0] == 2'h0 && hrdata[31:8] == 24'h0))
        else $error("reserved flags bits read nonzero");

    a_read_wait: assert property (
        @(posedge core_clk) disable iff (reset)
        (hsel && htrans[1] && hready && !hwrite)
        |=> !hreadyout ##1 hreadyout)
        else $error("read did not take exactly one wait state");

    a_irq_event: assert property (
        @(posedge core_clk) disable iff (reset)
        (undervoltageResetCause && lowVoltageDetectorEnable
        && intMask[RSF_UV_BIT] && !wrPending) |=> irq)
        else $error("unmasked undervoltage event raised no irq");

endmodule // rsf_reset_source_flags

// file: inc/rsf_pkg.sv
// Behaviour
// - Watchdog reset sets watchdog flag, bit 4.
// - Software writing zero clears watchdog flag.
// - Undervoltage reset also clears watchdog flag.
// - Undervoltage reset sets undervoltage flag, bit 2.
// - Reading the register clears undervoltage flag.
// - Undervoltage flag survives pin and watchdog resets.
// - Flags decode pin, watchdog or undervoltage source.
// - Detector disabled leaves undervoltage flag meaningless.
// - Register resets to 011x 0x00.
package rsf_pkg;

    //------------------------------------------------------------
    // Register byte offsets on the bus
    //------------------------------------------------------------
    localparam logic [7:0] RSF_FLAGS_OFF = 8'h00;   // Trim low and flags
    localparam logic [7:0] RSF_TRIMHI_OFF = 8'h04;  // Trim high bits
    localparam logic [7:0] RSF_STAT_OFF = 8'h08;    // Sticky event status
    localparam logic [7:0] RSF_MASK_OFF = 8'h0c;    // Interrupt mask

    //------------------------------------------------------------
    // Field positions of the flags register
    //------------------------------------------------------------
    localparam int RSF_TRIM_MSB = 6;     // Upper trim low bit
    localparam int RSF_TRIM_LSB = 5;     // Lower trim low bit
    localparam int RSF_WDG_BIT = 4;      // Watchdog reset flag
    localparam int RSF_UV_BIT = 2;       // Undervoltage reset flag

    //------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------
    localparam logic [1:0] RSF_TRIM_LOW_RST = 2'h3;  // Trim low bits high
    localparam logic [7:0] RSF_TRIM_HIGH_RST = 8'h80; // Mid-scale trim
    localparam logic [7:0] RSF_MASK_RST = 8'h00;     // All masked
    localparam logic [7:0] RSF_EVENT_BITS = 8'h14;   // Bits 4 and 2 only

    //------------------------------------------------------------
    // Read data path state, one-hot
    //------------------------------------------------------------
    typedef enum logic [2:0] {
        RSF_BUS_IDLE = 3'b001,    // No read in flight
        RSF_BUS_RDWAIT = 3'b010,  // Read data being fetched
        RSF_BUS_RDDONE = 3'b100   // Read data on the bus
    } rsf_bus_state_t;

endpackage

// file: verilog/rsf_flag_keeper.sv
//----------------------------------------------------------------
// Reset source flag keeper
//----------------------------------------------------------------
// These flags must outlive the ordinary system reset, so only the
// power-on clear, the recorded causes and the software clears touch them.
module rsf_flag_keeper
    import rsf_pkg::*;
(
    input wire logic core_clk,
    input wire logic powerOnReset,
    input wire logic watchdogResetCause,
    input wire logic undervoltageResetCause,
    input wire logic lowVoltageDetectorEnable,
    input wire logic watchdogFlagClear,
    input wire logic undervoltageFlagClear,
    output logic watchdogResetFlag,
    output logic undervoltageResetFlag
);

    //------------------------------------------------------------
    // Watchdog flag
    //------------------------------------------------------------
    // After the power-on clear, undervoltage wins over everything, then a hardware set beats
    // the software clear arriving in the same cycle
    always_ff @(posedge core_clk)
    begin
        if (powerOnReset)
        begin
            watchdogResetFlag <= 1'b0;
        end
        else if (undervoltageResetCause)
        begin
            watchdogResetFlag <= 1'b0;
        end
        else if (watchdogResetCause)
        begin
            watchdogResetFlag <= 1'b1;
        end
        else if (watchdogFlagClear)
        begin
            watchdogResetFlag <= 1'b0;
        end
    end

    //------------------------------------------------------------
    // Undervoltage flag
    //------------------------------------------------------------
    // Pin and watchdog resets leave it alone; only a read or the power-on clear clears it
    always_ff @(posedge core_clk)
    begin
        if (powerOnReset)
        begin
            undervoltageResetFlag <= 1'b0;
        end
        else if (undervoltageResetCause && lowVoltageDetectorEnable)
        begin
            undervoltageResetFlag <= 1'b1;
        end
        else if (undervoltageFlagClear)
        begin
            undervoltageResetFlag <= 1'b0;
        end
    end

endmodule // rsf_flag_keeper

// file: tb/tb.sv
module tb
    import rsf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    //------------------------------------------------------------
    // Clock, reset and bus signals
    //------------------------------------------------------------
    logic core_clk = 1'b0;   // 25 MHz core clock
    logic reset;             // System reset
    logic powerOnReset;      // Power-on clear of the flags
    logic wdgCause;          // Watchdog reset cause
    logic uvCause;           // Detector reset cause
    logic lvdEnable;         // Detector option setting
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [9:0] oscTrimWord;
    logic [31:0] rd;         // Last read data
    int errCount = 0;        // Mismatches seen
    int checks = 0;          // Comparisons made

    // Half period of 20 ns
    always #20 core_clk = ~core_clk;

    rsf_reset_source_flags rsf_reset_source_flags_i (
        .core_clk(core_clk),
        .reset(reset),
        .powerOnReset(powerOnReset),
        .watchdogResetCause(wdgCause),
        .undervoltageResetCause(uvCause),
        .lowVoltageDetectorEnable(lvdEnable),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .irq(irq),
        .oscTrimWord(oscTrimWord)
    );

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Flags register image from its fields
    function automatic logic [31:0] img(input logic [1:0] t,
                                        input logic w, input logic u);
        return {24'h0, 1'b0, t, w, 1'b0, u, 2'b00};
    endfunction

    // Waits for hready high at a falling edge, data taken there, then moves on to the rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50)
            chk(32'h1, 32'h0);
        @(posedge core_clk);
    endtask

    // One single word transfer; entered just after a rising edge
    task automatic bus(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        chk({31'h0, hresp}, 32'h0);
    endtask

    // Read and compare
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(a, 1'b0, 32'h0);
        chk(rd, exp);
    endtask

    // One cycle of reset causes, optionally with system reset
    task automatic cause(input logic w, input logic u, input logic r);
        wdgCause <= w;
        uvCause <= u;
        reset <= r;
        @(posedge core_clk);
        wdgCause <= 1'b0;
        uvCause <= 1'b0;
        reset <= 1'b0;
        @(posedge core_clk);
    endtask

    // Interrupt level checked mid-cycle
    task automatic irqchk(input logic exp);
        @(negedge core_clk);
        chk({31'h0, irq}, {31'h0, exp});
        @(posedge core_clk);
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    // Values after power-on and system reset
    task automatic t_reset();
        rdchk(RSF_FLAGS_OFF, img(RSF_TRIM_LOW_RST, 1'b0, 1'b0));
        rdchk(RSF_TRIMHI_OFF, {24'h0, RSF_TRIM_HIGH_RST});
        rdchk(RSF_MASK_OFF, {24'h0, RSF_MASK_RST});
        chk({22'h0, oscTrimWord}, {22'h0, RSF_TRIM_HIGH_RST, 2'h3});
        irqchk(1'b0);
        $display("test reset done");
    endtask

    // Watchdog flag set, write-one kept, write-zero clears
    task automatic t_watchdog();
        bus(RSF_MASK_OFF, 1'b1, 32'h14);
        cause(1'b1, 1'b0, 1'b0);
        irqchk(1'b1);
        rdchk(RSF_FLAGS_OFF, img(2'h3, 1'b1, 1'b0));
        rdchk(RSF_STAT_OFF, 32'h10);
        irqchk(1'b0);
        rdchk(RSF_STAT_OFF, 32'h0);
        bus(RSF_FLAGS_OFF, 1'b1, 32'h50);
        rdchk(RSF_FLAGS_OFF, img(2'h2, 1'b1, 1'b0));
        chk({30'h0, oscTrimWord[1:0]}, 32'h2);
        bus(RSF_FLAGS_OFF, 1'b1, 32'h40);
        rdchk(RSF_FLAGS_OFF, img(2'h2, 1'b0, 1'b0));
        $display("test watchdog done");
    endtask

    // Detector reset sets its flag, clears watchdog; read clears
    task automatic t_undervolt();
        cause(1'b1, 1'b0, 1'b0);
        cause(1'b0, 1'b1, 1'b0);
        rdchk(RSF_FLAGS_OFF, img(2'h2, 1'b0, 1'b1));
        rdchk(RSF_FLAGS_OFF, img(2'h2, 1'b0, 1'b0));
        rdchk(RSF_STAT_OFF, 32'h14);
        $display("test undervoltage done");
    endtask

    // Detector flag survives a later watchdog and system reset
    task automatic t_sticky();
        cause(1'b0, 1'b1, 1'b0);
        cause(1'b1, 1'b0, 1'b1);
        irqchk(1'b0);
        rdchk(RSF_FLAGS_OFF, img(2'h3, 1'b1, 1'b1));
        rdchk(RSF_FLAGS_OFF, img(2'h3, 1'b1, 1'b0));
        $display("test sticky done");
    endtask

    // Detector disabled: cause leaves its flag clear
    task automatic t_disabled();
        lvdEnable <= 1'b0;
        cause(1'b0, 1'b1, 1'b0);
        rdchk(RSF_FLAGS_OFF, img(2'h3, 1'b0, 1'b0));
        lvdEnable <= 1'b1;
        $display("test disabled done");
    endtask

    // Unmapped place, read-only status, mask width
    task automatic t_map();
        rdchk(RSF_STAT_OFF, 32'h10); // cause kept through system reset
        bus(8'h10, 1'b1, 32'hff);
        rdchk(8'h10, 32'h0);
        bus(RSF_STAT_OFF, 1'b1, 32'h14);
        rdchk(RSF_STAT_OFF, 32'h0);
        bus(RSF_MASK_OFF, 1'b1, 32'hff);
        rdchk(RSF_MASK_OFF, 32'h14);
        bus(RSF_TRIMHI_OFF, 1'b1, 32'h5a);
        // Let the write edge settle before looking at the trim word
        @(negedge core_clk);
        chk({22'h0, oscTrimWord}, {22'h0, 8'h5a, 2'h3});
        $display("test map done");
    endtask

    //------------------------------------------------------------
    // Verdict and sequence
    //------------------------------------------------------------
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        reset = 1'b1;
        powerOnReset = 1'b1;
        wdgCause = 1'b0;
        uvCause = 1'b0;
        lvdEnable = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge core_clk);
        reset <= 1'b0;
        powerOnReset <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_watchdog();
        t_undervolt();
        t_sticky();
        t_disabled();
        t_map();
        final_report();
    end

    // Cuts a hang short well past the expected run
    initial
    begin
        #(40 * 3000);
        errCount++;
        final_report();
    end

endmodule // tb
